// >>> cvsup_pkg.sv
// Notes on behaviour
// - Host sets enable, setpoints, direction, thresholds
// - Trips latch off; only enable command clears
// - Out-of-limit setpoint or threshold trips latch
// - Operate only with both voltages in range
// - Direction change: ramp to zero, wait 30 ms
// - Constant current regulates low side current
// - Power loss while active, or on/off falling edge, latches off
// - Start only above both turn-on thresholds
// - Below turn-off threshold latches undervoltage
// - Restart needs voltages up and on/off high
// - Hysteresis: high side buck, low side boost
// - Default undervoltage thresholds until host programs
// - Enable honoured only while on/off high
// - On/off falling edge shuts down, latches
// - On/off rising edge alone never enables
// - Current setpoint 1 to 250 A, zero refused
// - Soft-start ramp on setpoint; live changes
// - Precharge masks high side undervoltage 200 ms
// - Readback positive in buck, negative boost
// - Voltage setpoint outside range refused
// - CV below ramped current reference, else constant current
package cvsup_pkg;
	localparam int unsigned VW          = 12;             // Voltage code width, 10 mV steps
	localparam int unsigned IW          = 8;              // Current code width, 1 A steps
	localparam int unsigned TW          = 8;              // Temperature code width, degC
	localparam logic [IW-1:0] ISP_MIN   = 8'h01;          // 1 A
	localparam logic [IW-1:0] ISP_MAX   = 8'hFA;          // 250 A
	localparam logic [VW-1:0] VSET_MIN  = 12'h0_258;      // 6 V
	localparam logic [VW-1:0] VSET_MAX  = 12'h0_910;      // Highest voltage set point code
	localparam logic [VW-1:0] UV_MIN    = 12'h0_258;      // Lowest programmable undervoltage
	localparam logic [VW-1:0] OV_MAX    = 12'h0_910;      // Highest programmable overvoltage
	localparam logic [TW-1:0] OT_MAX    = 8'h78;          // 120 degC
	localparam logic [VW-1:0] LO_UV_ON  = 12'h0_2BC;      // Default low side turn-on
	localparam logic [VW-1:0] LO_UV_OFF = 12'h0_258;      // Default low side turn-off
	localparam logic [VW-1:0] HI_UV_ON  = 12'h0_960;      // Default high side turn-on
	localparam logic [VW-1:0] HI_UV_OFF = 12'h0_8FC;      // Default high side turn-off
	localparam int unsigned CLK_HZ      = 40_000_000;     // sys_clk rate
	localparam int unsigned DIR_MS      = 30;             // Direction change delay
	localparam int unsigned PRE_MS      = 200;            // Precharge undervoltage mask
	localparam int unsigned DIR_CYC     = DIR_MS * (CLK_HZ / 1000);
	localparam int unsigned PRE_CYC     = PRE_MS * (CLK_HZ / 1000);
	localparam int unsigned RAMP_DIV    = 4000;           // Cycles per 1 A ramp step
	typedef enum logic [2:0] {
		CVSUP_OFF   = 3'b000,
		CVSUP_RUN   = 3'b001,
		CVSUP_RDOWN = 3'b010,
		CVSUP_WAIT  = 3'b011,
		CVSUP_STOP  = 3'b100
	} cvsup_state_e;
	localparam int unsigned FLT_UV    = 0;                // Fault bit positions
	localparam int unsigned FLT_OV    = 1;
	localparam int unsigned FLT_OT    = 2;
	localparam int unsigned FLT_LIM   = 3;
	localparam int unsigned FLT_ONOFF = 4;
	localparam int unsigned FLT_EXT   = 5;
	localparam int unsigned FW        = 6;
endpackage

// >>> cvsup_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module cvsup_sync #(
	parameter int unsigned N = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] async_in,
	output logic      [N-1:0] sync_out
);
	logic [N-1:0] meta_ff; // First stage, read only by sync_out
	// First stage never feeds logic
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// >>> cvsup_ramp.sv
`timescale 1ns/1ps
// Soft-start ramp: steps the applied current one code toward target
module cvsup_ramp #(
	parameter int unsigned IW  = 8,
	parameter int unsigned DIV = 4000
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic [IW-1:0] target,
	output logic      [IW-1:0] level_ff,
	output logic               at_target_ff
);
	logic [$clog2(DIV)-1:0] div_ff; // Step prescaler
	// Prescaler limits slew, keeping cable inductive drop low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			div_ff <= '0;
		else if (div_ff == ($clog2(DIV))'(DIV - 1))
			div_ff <= '0;
		else
			div_ff <= div_ff + 1'b1;
	end
	// One step per prescaler wrap
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			level_ff <= '0;
		else if (div_ff == ($clog2(DIV))'(DIV - 1))
		begin
			if (level_ff < target)
				level_ff <= level_ff + 1'b1;
			else if (level_ff > target)
				level_ff <= level_ff - 1'b1;
		end
	end
	// Registered arrival flag
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			at_target_ff <= 1'b1;
		else
			at_target_ff <= (level_ff == target);
	end
endmodule

// >>> cvsup_top.sv
`timescale 1ns/1ps
// Supervisory sequencer of the bidirectional converter
module cvsup_top #(
	parameter int unsigned DIR_CYC = cvsup_pkg::DIR_CYC,  // Direction change delay
	parameter int unsigned PRE_CYC = cvsup_pkg::PRE_CYC,  // Precharge mask window
	parameter int unsigned RAMP_DIV = cvsup_pkg::RAMP_DIV // Ramp slew prescaler
) (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// Command side
	input  wire logic                          cmd_enable,          // Enable pulse
	input  wire logic                          cmd_disable,         // Disable pulse
	input  wire logic                          cmd_write,           // Set point write pulse
	input  wire logic [cvsup_pkg::IW-1:0]      cmd_current_setpoint,
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_voltage_setpoint,
	input  wire logic                          cmd_dir_boost,       // 0 buck, 1 boost
	input  wire logic                          cmd_precharge,
	input  wire logic                          cmd_uv_write,        // Undervoltage threshold write
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_low_side_uv_on,
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_low_side_uv_off,
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_high_side_uv_on,
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_high_side_uv_off,
	input  wire logic                          cmd_prot_write,      // OV / OT write
	input  wire logic [cvsup_pkg::VW-1:0]      cmd_ov_thresh,
	input  wire logic [cvsup_pkg::TW-1:0]      cmd_ot_thresh,
	// Pins and monitors
	input  wire logic                          onoff_pin,           // Remote on/off, async
	input  wire logic                          ext_power_ok,        // External bias, async
	input  wire logic [cvsup_pkg::VW-1:0]      low_side_v,
	input  wire logic [cvsup_pkg::VW-1:0]      high_side_v,
	input  wire logic [cvsup_pkg::IW-1:0]      low_side_i,          // Magnitude
	input  wire logic [cvsup_pkg::IW-1:0]      high_side_i,
	input  wire logic [cvsup_pkg::TW-1:0]      temp_c,
	// Status and power stage control
	output logic                               run_ff,              // Power stage enabled
	output logic                               boost_ff,            // Active direction
	output logic                               constant_current_mode_ff,
	output logic                               constant_voltage_mode_ff,
	output logic [cvsup_pkg::IW-1:0]           iref_ff,             // Ramped current reference
	output logic [cvsup_pkg::VW-1:0]           vref_ff,
	output logic                               latched_ff,
	output logic [cvsup_pkg::FW-1:0]           fault_ff,
	output logic signed [cvsup_pkg::IW:0]      low_side_rb_ff,
	output logic signed [cvsup_pkg::IW:0]      high_side_rb_ff
);
	localparam int unsigned CW = $clog2((DIR_CYC > PRE_CYC ? DIR_CYC : PRE_CYC) + 1);

	cvsup_pkg::cvsup_state_e st_ff, nxt_st; // Sequencer state
	logic [1:0]                     pins_s;     // Synchronised on/off and bias
	logic                           onoff_prev_ff; // For edge detect
	logic [cvsup_pkg::IW-1:0]       isp_ff;     // Accepted current set point
	logic                           dir_ff;     // Requested direction
	logic                           pre_ff;     // Precharge request
	logic [cvsup_pkg::VW-1:0]       lo_on_ff, lo_off_ff, hi_on_ff, hi_off_ff;
	logic [cvsup_pkg::VW-1:0]       ov_ff;
	logic [cvsup_pkg::TW-1:0]       ot_ff;
	logic [CW-1:0]                  wait_ff;    // Direction delay counter
	logic [CW-1:0]                  pre_cnt_ff; // Precharge mask counter
	logic [cvsup_pkg::IW-1:0]       ramp_tgt;
	logic [cvsup_pkg::IW-1:0]       ramp_lvl;
	logic                           ramp_done;
	logic [cvsup_pkg::FW-1:0]       trip;       // Fault causes this cycle
	logic                           enable_ok;
	logic                           lo_uv, hi_uv;

	// Window check used by the current and voltage set points
	function automatic logic in_lim(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		in_lim = (v >= lo) && (v <= hi);
	endfunction

	// Pins come from outside the clock domain
	cvsup_sync #(.N(2)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({ext_power_ok, onoff_pin}),
		.sync_out (pins_s)
	);

	// Ramp target drops to zero whenever the stage must not push current
	assign ramp_tgt = (st_ff == cvsup_pkg::CVSUP_RUN) ? isp_ff : '0;

	cvsup_ramp #(.IW(cvsup_pkg::IW), .DIV(RAMP_DIV)) u_ramp (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.target       (ramp_tgt),
		.level_ff     (ramp_lvl),
		.at_target_ff (ramp_done)
	);

	// Previous on/off level, for the falling edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			onoff_prev_ff <= 1'b0;
		else
			onoff_prev_ff <= pins_s[0];
	end

	// Set points; live changes allowed, host owns the values
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			isp_ff  <= '0;
			vref_ff <= '0;
			dir_ff  <= 1'b0;
			pre_ff  <= 1'b0;
		end
		else if (cmd_write)
		begin
			isp_ff  <= cmd_current_setpoint;
			vref_ff <= cmd_voltage_setpoint;
			dir_ff  <= cmd_dir_boost;
			pre_ff  <= cmd_precharge;
		end
	end

	// Thresholds start at defaults so an unprogrammed unit still protects
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lo_on_ff  <= cvsup_pkg::LO_UV_ON;
			lo_off_ff <= cvsup_pkg::LO_UV_OFF;
			hi_on_ff  <= cvsup_pkg::HI_UV_ON;
			hi_off_ff <= cvsup_pkg::HI_UV_OFF;
		end
		else if (cmd_uv_write)
		begin
			lo_on_ff  <= cmd_low_side_uv_on;
			lo_off_ff <= cmd_low_side_uv_off;
			hi_on_ff  <= cmd_high_side_uv_on;
			hi_off_ff <= cmd_high_side_uv_off;
		end
	end

	// Over-voltage and over-temperature thresholds
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ov_ff <= cvsup_pkg::OV_MAX;
			ot_ff <= cvsup_pkg::OT_MAX;
		end
		else if (cmd_prot_write)
		begin
			ov_ff <= cmd_ov_thresh;
			ot_ff <= cmd_ot_thresh;
		end
	end

	// Hysteresis: the input-side rail uses the lower turn-off level
	always_comb
	begin
		lo_uv = boost_ff ? (low_side_v < lo_off_ff) : (low_side_v < lo_on_ff);
		hi_uv = boost_ff ? (high_side_v < hi_on_ff) : (high_side_v < hi_off_ff);
		if (pre_cnt_ff != '0)
			hi_uv = 1'b0;
	end

	// Fault causes; rails, temperature and bias checked only while running or sequencing
	always_comb
	begin
		trip = '0;
		if (st_ff != cvsup_pkg::CVSUP_OFF && st_ff != cvsup_pkg::CVSUP_STOP)
		begin
			trip[cvsup_pkg::FLT_UV]    = lo_uv || hi_uv;
			trip[cvsup_pkg::FLT_OV]    = (low_side_v > ov_ff) || (high_side_v > ov_ff);
			trip[cvsup_pkg::FLT_OT]    = temp_c > ot_ff;
			trip[cvsup_pkg::FLT_ONOFF] = onoff_prev_ff && !pins_s[0];
			trip[cvsup_pkg::FLT_EXT]   = !pins_s[1];
		end
		else
			trip[cvsup_pkg::FLT_ONOFF] = onoff_prev_ff && !pins_s[0];
		trip[cvsup_pkg::FLT_LIM] = !in_lim(16'(isp_ff), 16'(cvsup_pkg::ISP_MIN), 16'(cvsup_pkg::ISP_MAX))
			|| !in_lim(16'(vref_ff), 16'(cvsup_pkg::VSET_MIN), 16'(cvsup_pkg::VSET_MAX))
			|| (lo_off_ff < cvsup_pkg::UV_MIN) || (hi_off_ff < cvsup_pkg::UV_MIN)
			|| (ov_ff > cvsup_pkg::OV_MAX) || (ot_ff > cvsup_pkg::OT_MAX);
		if (st_ff == cvsup_pkg::CVSUP_OFF && !enable_ok)
			trip[cvsup_pkg::FLT_LIM] = 1'b0; // Ignored only while idle without an enable
	end

	// Start needs on/off high, bias, both rails above turn-on
	assign enable_ok = cmd_enable && pins_s[0] && pins_s[1]
		&& (low_side_v >= lo_on_ff) && (high_side_v >= hi_on_ff);

	// Sequencer next state
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			cvsup_pkg::CVSUP_OFF:
				if (enable_ok && trip == '0)
					nxt_st = cvsup_pkg::CVSUP_RUN;
			cvsup_pkg::CVSUP_RUN:
				if (trip != '0)
					nxt_st = cvsup_pkg::CVSUP_STOP;
				else if (cmd_disable)
					nxt_st = cvsup_pkg::CVSUP_OFF;
				else if (dir_ff != boost_ff)
					nxt_st = cvsup_pkg::CVSUP_RDOWN;
			cvsup_pkg::CVSUP_RDOWN:
				if (trip != '0)
					nxt_st = cvsup_pkg::CVSUP_STOP;
				else if (ramp_lvl == '0)
					nxt_st = cvsup_pkg::CVSUP_WAIT;
			cvsup_pkg::CVSUP_WAIT:
				if (trip != '0)
					nxt_st = cvsup_pkg::CVSUP_STOP;
				else if (wait_ff == CW'(DIR_CYC - 1))
					nxt_st = cvsup_pkg::CVSUP_RUN;
			cvsup_pkg::CVSUP_STOP:
				if (enable_ok)
					nxt_st = cvsup_pkg::CVSUP_OFF;
			default:
				nxt_st = cvsup_pkg::CVSUP_STOP;
		endcase
		if (st_ff == cvsup_pkg::CVSUP_OFF && trip != '0)
			nxt_st = cvsup_pkg::CVSUP_STOP;
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= cvsup_pkg::CVSUP_OFF;
		else
			st_ff <= nxt_st;
	end

	// Direction delay counter
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wait_ff <= '0;
		else if (st_ff == cvsup_pkg::CVSUP_WAIT)
			wait_ff <= wait_ff + 1'b1;
		else
			wait_ff <= '0;
	end

	// Precharge mask armed on each entry into run while precharge is requested
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_cnt_ff <= '0;
		else if (nxt_st == cvsup_pkg::CVSUP_RUN && st_ff != cvsup_pkg::CVSUP_RUN && pre_ff)
			pre_cnt_ff <= CW'(PRE_CYC);
		else if (pre_cnt_ff != '0)
			pre_cnt_ff <= pre_cnt_ff - 1'b1;
	end

	// Active direction changes only while stopped from pushing current
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			boost_ff <= 1'b0;
		else if (st_ff != cvsup_pkg::CVSUP_RUN && st_ff != cvsup_pkg::CVSUP_RDOWN)
			boost_ff <= dir_ff;
	end

	// Power stage enable and ramped reference
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_ff  <= 1'b0;
			iref_ff <= '0;
		end
		else
		begin
			run_ff  <= (nxt_st == cvsup_pkg::CVSUP_RUN) || (nxt_st == cvsup_pkg::CVSUP_RDOWN);
			iref_ff <= ramp_lvl;
		end
	end

	// Regulation mode: current limit whenever load meets the ramped reference while running
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			constant_current_mode_ff <= 1'b0;
			constant_voltage_mode_ff <= 1'b0;
		end
		else
		begin
			constant_current_mode_ff <= run_ff && (low_side_i >= iref_ff);
			constant_voltage_mode_ff <= run_ff && (low_side_i < iref_ff);
		end
	end

	// Fault latch: a new trip wins over the clearing enable
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_ff   <= '0;
			latched_ff <= 1'b0;
		end
		else if (trip != '0)
		begin
			fault_ff   <= fault_ff | trip;
			latched_ff <= 1'b1;
		end
		else if (st_ff == cvsup_pkg::CVSUP_STOP && enable_ok)
		begin
			fault_ff   <= '0;
			latched_ff <= 1'b0;
		end
	end

	// Signed readback, sign follows direction
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			low_side_rb_ff  <= '0;
			high_side_rb_ff <= '0;
		end
		else
		begin
			low_side_rb_ff  <= boost_ff ? -$signed({1'b0, low_side_i}) : $signed({1'b0, low_side_i});
			high_side_rb_ff <= boost_ff ? -$signed({1'b0, high_side_i}) : $signed({1'b0, high_side_i});
		end
	end
	// Command and status ports stand in for the undocumented messages
endmodule

// >>> cvsup_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the supervisor; all properties sleep while reset is low
module cvsup_asserts (
	input  wire logic                            sys_clk,
	input  wire logic                            rst_n,
	input  wire logic                            cmd_enable,
	input  wire logic                            onoff_pin,
	input  wire logic                            ext_power_ok,
	input  wire logic [cvsup_pkg::IW-1:0]        low_side_i,
	input  wire logic                            run_ff,
	input  wire logic                            boost_ff,
	input  wire logic                            constant_current_mode_ff,
	input  wire logic                            constant_voltage_mode_ff,
	input  wire logic [cvsup_pkg::IW-1:0]        iref_ff,
	input  wire logic                            latched_ff,
	input  wire logic [cvsup_pkg::FW-1:0]        fault_ff,
	input  wire logic signed [cvsup_pkg::IW:0]   low_side_rb_ff
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// A latched fault keeps the stage off
	a_latch_stops_run: assert property (latched_ff |-> !run_ff)
		else $error("power stage on while latched");
	// Only an enable command may clear the latch
	a_latch_holds: assert property (latched_ff && !cmd_enable |=> latched_ff)
		else $error("latch cleared without enable");
	// Pin falls: synchroniser plus one register, so a few cycles
	a_onoff_fall_trip: assert property ($fell(onoff_pin) |-> ##[1:5] latched_ff && fault_ff[4])
		else $error("on/off fall did not latch");
	// Bias loss while running latches the external power fault
	a_ext_loss_trip: assert property ($fell(ext_power_ok) && run_ff |-> ##[1:5] fault_ff[5] && !run_ff)
		else $error("external power loss did not latch");
	// Synced pin low: an enable can never start the stage
	a_onoff_low_refuse: assert property (!run_ff && !onoff_pin && !$past(onoff_pin) && !$past(onoff_pin, 2)
		|=> !run_ff)
		else $error("started with on/off low");
	// A rising pin alone never starts the stage
	a_onoff_rise_idle: assert property ((!run_ff && $rose(onoff_pin)) ##0 (!cmd_enable)[*4] |=> !run_ff)
		else $error("started on pin rise");
	// Soft start climbs one code at a time
	a_ramp_one_step: assert property (iref_ff > $past(iref_ff) |-> iref_ff == $past(iref_ff) + 8'h01)
		else $error("reference jumped");
	// Reference stays at or below ISP_MAX while running
	a_iref_in_range: assert property (run_ff |-> iref_ff <= cvsup_pkg::ISP_MAX)
		else $error("reference above limit");
	// Direction flips only once current is down to zero
	a_dir_at_zero: assert property ($changed(boost_ff) && run_ff |-> iref_ff == 8'h00)
		else $error("direction changed with current flowing");
	// Readback sign follows the active direction
	a_rb_sign: assert property (run_ff && $stable(boost_ff) && $stable(low_side_i) |-> low_side_rb_ff ==
		(boost_ff ? -$signed({1'b0, low_side_i}) : $signed({1'b0, low_side_i})))
		else $error("readback sign wrong");
	// Regulation modes are exclusive
	a_mode_exclusive: assert property (!(constant_current_mode_ff && constant_voltage_mode_ff)
		&& ((constant_current_mode_ff ^ constant_voltage_mode_ff) == $past(run_ff)))
		else $error("both regulation modes set");
	c_start: cover property ($rose(run_ff));
	c_boost_run: cover property ($rose(boost_ff) && run_ff);
	c_uv_latch: cover property ($rose(latched_ff) && fault_ff[cvsup_pkg::FLT_UV]);
endmodule

bind cvsup_top cvsup_asserts chk_u (.sys_clk, .rst_n, .cmd_enable, .onoff_pin, .ext_power_ok, .low_side_i,
	.run_ff, .boost_ff, .constant_current_mode_ff, .constant_voltage_mode_ff, .iref_ff, .latched_ff,
	.fault_ff, .low_side_rb_ff);

// >>> cvsup_host.sv
`timescale 1ns/1ps
// Host model: fields held as levels, strobes one cycle wide, all moved 1 ns past the edge
module cvsup_host (
	input  wire logic        sys_clk,
	output logic             cmd_enable,
	output logic             cmd_disable,
	output logic             cmd_write,
	output logic             cmd_uv_write,
	output logic             cmd_prot_write,
	output logic [7:0]       cmd_current_setpoint,
	output logic [11:0]      cmd_voltage_setpoint,
	output logic             cmd_dir_boost,
	output logic             cmd_precharge,
	output logic [11:0]      cmd_low_side_uv_on,
	output logic [11:0]      cmd_low_side_uv_off,
	output logic [11:0]      cmd_high_side_uv_on,
	output logic [11:0]      cmd_high_side_uv_off,
	output logic [11:0]      cmd_ov_thresh,
	output logic [7:0]       cmd_ot_thresh,
	output logic             onoff_pin,
	output logic             ext_power_ok
);
	logic [4:0] pulse; // One bit per strobe, so two can never overlap by accident
	assign {cmd_prot_write, cmd_uv_write, cmd_write, cmd_disable, cmd_enable} = pulse;
	// On/off starts low, bias high: the device powers up with on/off inactive
	initial
	begin
		pulse = 5'h00;
		{cmd_current_setpoint, cmd_voltage_setpoint, cmd_dir_boost, cmd_precharge} = '0;
		{cmd_low_side_uv_on, cmd_low_side_uv_off, cmd_high_side_uv_on, cmd_high_side_uv_off} = '0;
		{cmd_ov_thresh, cmd_ot_thresh} = '0;
		onoff_pin = 1'b0;
		ext_power_ok = 1'b1;
	end
	// One strobe held across exactly one rising edge
	task automatic strobe(input logic [4:0] k);
		@(posedge sys_clk);
		#1 pulse = k;
		@(posedge sys_clk);
		#1 pulse = 5'h00;
	endtask
	// Set points and direction, taken on the write strobe
	task automatic sp(input logic [7:0] i, input logic [11:0] v, input logic b, input logic pc);
		{cmd_current_setpoint, cmd_voltage_setpoint, cmd_dir_boost, cmd_precharge} = {i, v, b, pc};
		strobe(5'h04);
	endtask
	task automatic uv(input logic [11:0] lon, input logic [11:0] loff, input logic [11:0] hon, input logic [11:0] hoff);
		{cmd_low_side_uv_on, cmd_low_side_uv_off, cmd_high_side_uv_on, cmd_high_side_uv_off} = {lon, loff, hon, hoff};
		strobe(5'h08);
	endtask
	task automatic prot(input logic [11:0] ov, input logic [7:0] ot);
		{cmd_ov_thresh, cmd_ot_thresh} = {ov, ot};
		strobe(5'h10);
	endtask
	task automatic en();
		strobe(5'h01);
	endtask
	task automatic dis();
		strobe(5'h02);
	endtask
	task automatic pins(input logic on, input logic ext);
		onoff_pin = on;
		ext_power_ok = ext;
	endtask
endmodule

// >>> cvsup_top_bench.sv
`timescale 1ns/1ps
// Bench: host model sends commands, bench drives rails and sensors
module cvsup_top_bench;
	logic        sys_clk, rst_n, cmd_enable, cmd_disable, cmd_write, cmd_uv_write, cmd_prot_write;
	logic        cmd_dir_boost, cmd_precharge, onoff_pin, ext_power_ok;
	logic [7:0]  cmd_current_setpoint, cmd_ot_thresh, low_side_i, high_side_i, temp_c, iref_ff;
	logic [11:0] cmd_voltage_setpoint, cmd_low_side_uv_on, cmd_low_side_uv_off, cmd_ov_thresh;
	logic [11:0] cmd_high_side_uv_on, cmd_high_side_uv_off, low_side_v, high_side_v, vref_ff;
	logic        run_ff, boost_ff, constant_current_mode_ff, constant_voltage_mode_ff, latched_ff;
	logic [5:0]  fault_ff;
	logic signed [8:0] low_side_rb_ff, high_side_rb_ff;
	int          bad_count, checks_done, k;
	// Bad set point table: zero, 251 A, volts high, volts low, OV high, OT high
	logic [7:0]  bad_i [6] = '{8'h00, 8'hFB, 8'h0A, 8'h0A, 8'h0A, 8'h0A};
	logic [11:0] bad_v [6] = '{12'h0400, 12'h0400, 12'h0911, 12'h0257, 12'h0400, 12'h0400};
	logic [11:0] bad_o [6] = '{12'h0900, 12'h0900, 12'h0900, 12'h0900, 12'h0911, 12'h0900};
	logic [7:0]  bad_t [6] = '{8'h78, 8'h78, 8'h78, 8'h78, 8'h78, 8'h79};
	// Short counts keep the run small
	cvsup_top #(.DIR_CYC(20), .PRE_CYC(50), .RAMP_DIV(2)) dut_u (.sys_clk, .rst_n, .cmd_enable, .cmd_disable,
		.cmd_write, .cmd_current_setpoint, .cmd_voltage_setpoint, .cmd_dir_boost, .cmd_precharge, .cmd_uv_write,
		.cmd_low_side_uv_on, .cmd_low_side_uv_off, .cmd_high_side_uv_on, .cmd_high_side_uv_off, .cmd_prot_write,
		.cmd_ov_thresh, .cmd_ot_thresh, .onoff_pin, .ext_power_ok, .low_side_v, .high_side_v, .low_side_i,
		.high_side_i, .temp_c, .run_ff, .boost_ff, .constant_current_mode_ff, .constant_voltage_mode_ff,
		.iref_ff, .vref_ff, .latched_ff, .fault_ff, .low_side_rb_ff, .high_side_rb_ff);
	cvsup_host host_u (.sys_clk, .cmd_enable, .cmd_disable, .cmd_write, .cmd_uv_write, .cmd_prot_write,
		.cmd_current_setpoint, .cmd_voltage_setpoint, .cmd_dir_boost, .cmd_precharge, .cmd_low_side_uv_on,
		.cmd_low_side_uv_off, .cmd_high_side_uv_on, .cmd_high_side_uv_off, .cmd_ov_thresh, .cmd_ot_thresh,
		.onoff_pin, .ext_power_ok);
	// 40 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Advance whole cycles, landing 1 ns past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic cond(input int s);
		case (s)
			0: return iref_ff === 8'h0A;
			1: return boost_ff === 1'b1 && run_ff === 1'b1;
			default: return latched_ff === 1'b1;
		endcase
	endfunction
	// Bounded wait; running out ends the run as a failure
	task automatic wt(input int s, input int n, output int c);
		for (c = 0; c < n && !cond(s); c++)
			cyc(1);
		if (!cond(s))
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t wait %h bound %h", $time, s, n);
			give_verdict();
		end
	endtask
	// First enable clears the latch into idle, the second starts
	task automatic restart();
		host_u.en();
		cyc(2);
		chk(latched_ff, 0);
		chk(run_ff, 0);
		host_u.en();
		cyc(2);
		chk(run_ff, 1);
	endtask
	initial
	begin
		{rst_n, low_side_i, high_side_i} = '0;
		{low_side_v, high_side_v, temp_c} = {12'h0320, 12'h0700, 8'h19};
		repeat (12) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		cyc(1);
		chk({run_ff, latched_ff, fault_ff}, 0);
		host_u.uv(12'h0300, 12'h0280, 12'h0600, 12'h0500);
		host_u.prot(12'h0900, 8'h78);
		host_u.sp(8'h0A, 12'h0400, 1'b0, 1'b0);
		host_u.en();
		cyc(3);
		chk(run_ff, 0);
		host_u.pins(1'b1, 1'b1);
		cyc(6);
		chk(run_ff, 0);
		host_u.en();
		cyc(1);
		chk({run_ff, boost_ff}, 2);
		chk(vref_ff, 12'h400);
		low_side_i = 8'h14; // Load above set point forces current limiting
		high_side_i = 8'h03;
		wt(0, 100, k);
		cyc(4);
		chk({constant_current_mode_ff, constant_voltage_mode_ff}, 2);
		chk({3'h0, low_side_rb_ff}, 12'h014);
		chk({3'h0, high_side_rb_ff}, 12'h003);
		low_side_i = 8'h05; // Host keeps set point above load here
		cyc(4);
		chk({constant_current_mode_ff, constant_voltage_mode_ff}, 1);
		host_u.sp(8'h0A, 12'h0400, 1'b1, 1'b0);
		wt(1, 200, k);
		chk(k >= 38, 1);
		cyc(2);
		chk({3'h0, low_side_rb_ff}, 12'h1FB);
		chk({3'h0, high_side_rb_ff}, 12'h1FD);
		// Boost: low side judged on turn-off level only
		low_side_v = 12'h0290;
		cyc(8);
		chk(latched_ff, 0);
		low_side_v = 12'h0270;
		wt(2, 20, k);
		chk({run_ff, fault_ff}, 7'h01);
		low_side_v = 12'h0320;
		cyc(10);
		chk(latched_ff, 1);
		low_side_v = 12'h02F0;
		host_u.en();
		cyc(3);
		chk(latched_ff, 1);
		low_side_v = 12'h0320;
		host_u.pins(1'b0, 1'b1);
		cyc(4);
		host_u.en();
		cyc(3);
		chk(latched_ff, 1);
		host_u.pins(1'b1, 1'b1);
		cyc(6);
		chk(latched_ff, 1);
		restart();
		host_u.pins(1'b1, 1'b0);
		wt(2, 20, k);
		chk(fault_ff, 6'h20);
		host_u.pins(1'b1, 1'b1);
		cyc(4);
		restart();
		host_u.pins(1'b0, 1'b1);
		wt(2, 20, k);
		chk(fault_ff, 6'h10);
		host_u.pins(1'b1, 1'b1);
		cyc(4);
		restart();
		temp_c = 8'h79;
		wt(2, 20, k);
		chk(fault_ff, 6'h04);
		temp_c = 8'h19;
		cyc(2);
		restart();
		low_side_v = 12'h0901;
		wt(2, 20, k);
		chk(fault_ff, 6'h02);
		low_side_v = 12'h0320;
		cyc(2);
		restart();
		host_u.dis();
		cyc(2);
		chk(run_ff, 0);
		for (int j = 0; j < 6; j++)
		begin
			host_u.sp(bad_i[j], bad_v[j], 1'b0, 1'b0);
			host_u.prot(bad_o[j], bad_t[j]);
			host_u.en();
			cyc(3);
			chk({run_ff, fault_ff}, 7'h08);
			host_u.sp(8'h0A, 12'h0400, 1'b0, 1'b0);
			host_u.prot(12'h0900, 8'h78);
			host_u.en();
			cyc(2);
			chk(latched_ff, 0);
		end
		// Edge values accepted; precharge masks high side undervoltage
		host_u.sp(8'h01, 12'h0910, 1'b0, 1'b1);
		host_u.en();
		cyc(1);
		chk(run_ff, 1);
		high_side_v = 12'h0400;
		cyc(30);
		chk(latched_ff, 0);
		wt(2, 100, k);
		chk(k >= 18 && k <= 22, 1);
		chk(fault_ff, 6'h01);
		give_verdict();
	end
endmodule
